// file: sdcp_defines.svh
`ifndef SDCP_DEFINES_SVH
`define SDCP_DEFINES_SVH
// Summary of operation
// RL1: Host waits for the busy bit to read 0 before issuing a command.
// RL2: Commands run only with drive ready set, except diagnostic and init parameters.
// RL3: Device sends register, PIO setup and DMA active frames; data frames both ways.
// RL4: Commands moving no payload are classed non-data and run without data frames.
// RL5: Non-data command completes with a device-to-host register frame, interrupt bit 1.
// RL6: Pending error on a data command skips data, sends register frame, interrupt 1.
// RL7: PIO data-in setup frame status carries busy 0, DRQ 1, interrupt 1.
// RL8: PIO data-in ending status is busy 0 on last burst, else busy 1; DRQ 0.
// RL9: PIO data-in sends one data frame after each setup frame until done.
// RL10: Every data frame burst carries at most 8 KB; longer transfers repeat bursts.
// RL11: PIO data-in ends after its last data frame with no closing register frame.
// RL12: PIO data-out setup carries busy 0, DRQ 1; interrupt 0 first burst, else 1.
// RL13: PIO data-out setup ending status carries busy 1 and DRQ 0.
// RL14: Host answers each PIO data-out setup frame with one data frame.
// RL15: Data-out ends with a register frame, interrupt 1, reporting any error found.
// RL16: DMA data-in sends data frames directly without any setup frame.
// RL17: DMA data-in closes with a register frame carrying interrupt bit 1.
// RL18: DMA data-out sends a DMA active frame before each burst it accepts.
// RL19: Host sends a DMA data-out data frame only after a DMA active frame.
// RL20: DMA completion is signalled by the interrupt bit of the final register frame.

// Transfer geometry
`define SDCP_SECT_BYTES    512
`define SDCP_WORD_BYTES    4
`define SDCP_BURST_BYTES   8192
`define SDCP_SECT_WORDS    (`SDCP_SECT_BYTES / `SDCP_WORD_BYTES)
`define SDCP_BURST_SECT    (`SDCP_BURST_BYTES / `SDCP_SECT_BYTES)
`define SDCP_FIFO_DEPTH    16
`define SDCP_ZERO_CNT_SECT 17'h10000

// Command opcodes
`define SDCP_OP_RECAL      8'h10
`define SDCP_OP_SEEK       8'h70
`define SDCP_OP_VERIFY     8'h40
`define SDCP_OP_VERIFY_X   8'h42
`define SDCP_OP_DIAG       8'h90
`define SDCP_OP_INIT_PAR   8'h91
`define SDCP_OP_SET_FEAT   8'hEF
`define SDCP_OP_SET_MULT   8'hC6
`define SDCP_OP_STBY_IMM   8'hE0
`define SDCP_OP_IDLE_IMM   8'hE1
`define SDCP_OP_STBY       8'hE2
`define SDCP_OP_IDLE       8'hE3
`define SDCP_OP_CHK_PWR    8'hE5
`define SDCP_OP_SLEEP      8'hE6
`define SDCP_OP_FLUSH      8'hE7
`define SDCP_OP_FLUSH_X    8'hEA
`define SDCP_OP_SMART      8'hB0
`define SDCP_OP_IDENT      8'hEC
`define SDCP_OP_RD_SECT    8'h20
`define SDCP_OP_RD_SECT_X  8'h24
`define SDCP_OP_RD_MULT    8'hC4
`define SDCP_OP_RD_BUF     8'hE4
`define SDCP_OP_RD_LOG_X   8'h2F
`define SDCP_OP_WR_SECT    8'h30
`define SDCP_OP_WR_SECT_X  8'h34
`define SDCP_OP_WR_MULT    8'hC5
`define SDCP_OP_WR_BUF     8'hE8
`define SDCP_OP_DL_UCODE   8'h92
`define SDCP_OP_WR_LOG_X   8'h3F
`define SDCP_OP_RD_DMA     8'hC8
`define SDCP_OP_RD_DMA_X   8'h25
`define SDCP_OP_IDENT_DMA  8'hEE
`define SDCP_OP_WR_DMA     8'hCA
`define SDCP_OP_WR_DMA_X   8'h35
`define SDCP_OP_WR_LOG_DMA 8'h57
`define SDCP_SMART_RD_DATA 8'hD0
`define SDCP_SMART_RD_LOG  8'hD5
`define SDCP_SMART_WR_LOG  8'hD6
`endif

// file: sdcp_pkg.sv
package sdcp_pkg;
  // Command classes
  typedef enum logic [2:0] {
    CL_ABORT   = 3'b000,
    CL_NODATA  = 3'b001,
    CL_PIO_IN  = 3'b010,
    CL_PIO_OUT = 3'b011,
    CL_DMA_IN  = 3'b100,
    CL_DMA_OUT = 3'b101
  } sdcp_cls_t;

  // Device frame kinds on the frame port
  typedef enum logic [1:0] {
    FT_D2H       = 2'b00,
    FT_PIO_SETUP = 2'b01,
    FT_DMA_ACT   = 2'b10
  } sdcp_ftype_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_WAIT = 3'b010,
    ST_PSET = 3'b011,
    ST_DACT = 3'b100,
    ST_DIN  = 3'b101,
    ST_DOUT = 3'b110,
    ST_REG  = 3'b111
  } sdcp_state_t;

  // Status byte layout
  typedef struct packed {
    logic bsy;
    logic drdy;
    logic df;
    logic dsc;
    logic drq;
    logic corr;
    logic idx;
    logic err;
  } sdcp_stat_t;

  // Command from a host-to-device register frame
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  feature;
    logic [15:0] count;
  } sdcp_cmd_t;

  // Device-to-host frame header
  typedef struct packed {
    sdcp_ftype_t ftype;
    logic        irq;
    sdcp_stat_t  status;
    sdcp_stat_t  e_status;
    logic [15:0] xfer_bytes;
  } sdcp_frm_t;
endpackage : sdcp_pkg

// file: sdcp_fifo.sv
`include "sdcp_defines.svh"
module sdcp_fifo #(
  parameter int W = 32,
  parameter int D = `SDCP_FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW:0]  wr_ff;
  logic [AW:0]  rd_ff;

  // Full when pointers differ only in the wrap bit
  wire logic full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire logic empty = (wr_ff == rd_ff);
  wire logic push  = in_valid_i && !full;
  wire logic pop   = out_ready_i && !empty;

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[rd_ff[AW-1:0]];

  // Pointer update
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= wr_ff + (AW+1)'(push);
      rd_ff <= rd_ff + (AW+1)'(pop);
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end
endmodule : sdcp_fifo

// file: sdcp_classify.sv
`include "sdcp_defines.svh"
module sdcp_classify (
  input  wire logic [7:0]        opcode_i,
  input  wire logic [7:0]        feature_i,
  output sdcp_pkg::sdcp_cls_t    cls_o,
  output logic                   exempt_o
);
  import sdcp_pkg::*;

  // Commands allowed while drive ready is low
  assign exempt_o = (opcode_i == `SDCP_OP_DIAG) || (opcode_i == `SDCP_OP_INIT_PAR); // RL2

  // Opcode to protocol class
  always_comb begin
    unique case (opcode_i)
      `SDCP_OP_RECAL, `SDCP_OP_SEEK, `SDCP_OP_VERIFY, `SDCP_OP_VERIFY_X,
      `SDCP_OP_DIAG, `SDCP_OP_INIT_PAR, `SDCP_OP_SET_FEAT, `SDCP_OP_SET_MULT,
      `SDCP_OP_STBY_IMM, `SDCP_OP_IDLE_IMM, `SDCP_OP_STBY, `SDCP_OP_IDLE,
      `SDCP_OP_CHK_PWR, `SDCP_OP_SLEEP, `SDCP_OP_FLUSH, `SDCP_OP_FLUSH_X: begin
        cls_o = CL_NODATA; // RL4
      end
      `SDCP_OP_SMART: begin
        if (feature_i == `SDCP_SMART_RD_DATA || feature_i == `SDCP_SMART_RD_LOG) begin
          cls_o = CL_PIO_IN;
        end else if (feature_i == `SDCP_SMART_WR_LOG) begin
          cls_o = CL_PIO_OUT;
        end else begin
          cls_o = CL_NODATA; // RL4
        end
      end
      `SDCP_OP_IDENT, `SDCP_OP_RD_SECT, `SDCP_OP_RD_SECT_X, `SDCP_OP_RD_MULT,
      `SDCP_OP_RD_BUF, `SDCP_OP_RD_LOG_X: begin
        cls_o = CL_PIO_IN;
      end
      `SDCP_OP_WR_SECT, `SDCP_OP_WR_SECT_X, `SDCP_OP_WR_MULT, `SDCP_OP_WR_BUF,
      `SDCP_OP_DL_UCODE, `SDCP_OP_WR_LOG_X: begin
        cls_o = CL_PIO_OUT;
      end
      `SDCP_OP_RD_DMA, `SDCP_OP_RD_DMA_X, `SDCP_OP_IDENT_DMA: begin
        cls_o = CL_DMA_IN;
      end
      `SDCP_OP_WR_DMA, `SDCP_OP_WR_DMA_X, `SDCP_OP_WR_LOG_DMA: begin
        cls_o = CL_DMA_OUT;
      end
      default: begin
        cls_o = CL_ABORT;
      end
    endcase
  end
endmodule : sdcp_classify

// file: sdcp_top.sv
`include "sdcp_defines.svh"
module sdcp_top #(
  parameter int DW = 32
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic              CMD_VALID_I,
  input  sdcp_pkg::sdcp_cmd_t    CMD_I,
  output logic                   CMD_READY_O,
  input  wire logic              DRDY_I,
  input  wire logic              ERR_PEND_I,
  input  wire logic              EXEC_DONE_I,
  input  wire logic              EXEC_ERR_I,
  input  wire logic              XFER_RDY_I,
  output logic                   BUSY_O,
  output logic                   FRM_VALID_O,
  output sdcp_pkg::sdcp_frm_t    FRM_O,
  input  wire logic              FRM_READY_I,
  output logic                   TXD_VALID_O,
  output logic [DW-1:0]          TXD_DATA_O,
  output logic                   TXD_LAST_O,
  input  wire logic              TXD_READY_I,
  input  wire logic              RXD_VALID_I,
  input  wire logic [DW-1:0]     RXD_DATA_I,
  input  wire logic              RXD_LAST_I,
  output logic                   RXD_READY_O,
  input  wire logic              MRD_VALID_I,
  input  wire logic [DW-1:0]     MRD_DATA_I,
  output logic                   MRD_READY_O,
  output logic                   MWR_VALID_O,
  output logic [DW-1:0]          MWR_DATA_O,
  input  wire logic              MWR_READY_I
);
  import sdcp_pkg::*;

  sdcp_state_t state_ff;
  sdcp_state_t nxt_state;
  sdcp_cls_t   cls_ff;
  sdcp_cls_t   cmd_cls;
  logic        cmd_exempt;
  logic        dir_in_ff;
  logic        first_ff;
  logic        err_ff;
  logic [16:0] remain_ff;
  logic [4:0]  burst_ff;
  logic [11:0] wcnt_ff;
  logic [23:0] mrd_left_ff;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [DW-1:0] fifo_out_data;

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  sdcp_classify u_classify (
    .opcode_i  (CMD_I.opcode),
    .feature_i (CMD_I.feature),
    .cls_o     (cmd_cls),
    .exempt_o  (cmd_exempt)
  );

  // Accept and screen a new command
  wire logic cmd_take   = CMD_VALID_I && (state_ff == ST_IDLE);
  wire logic cmd_refuse = (!DRDY_I && !cmd_exempt) || (cmd_cls == CL_ABORT); // RL2
  wire logic cmd_nodata = (cmd_cls == CL_NODATA);
  wire logic cmd_skip   = !cmd_nodata && ERR_PEND_I; // RL6
  wire logic cmd_dir_in = (cmd_cls == CL_PIO_IN) || (cmd_cls == CL_DMA_IN);
  wire logic [16:0] cmd_sect = (CMD_I.count == 16'h0) ? `SDCP_ZERO_CNT_SECT : {1'b0, CMD_I.count};

  // Burst sizing, at most 8 KB per data frame
  wire logic [4:0]  next_burst = (remain_ff > 17'(`SDCP_BURST_SECT)) ?
                                 5'(`SDCP_BURST_SECT) : remain_ff[4:0]; // RL10
  wire logic [11:0] next_words = 12'(next_burst * `SDCP_SECT_WORDS); // RL10
  wire logic        burst_last = (remain_ff == 17'(burst_ff));

  // Handshakes and burst end
  wire logic frm_hs    = FRM_VALID_O && FRM_READY_I;
  wire logic tx_hs     = TXD_VALID_O && TXD_READY_I;
  wire logic rx_hs     = RXD_VALID_I && RXD_READY_O;
  wire logic burst_go  = (state_ff == ST_WAIT) && XFER_RDY_I;
  wire logic in_end    = (state_ff == ST_DIN) && tx_hs && (wcnt_ff == 12'h1);
  wire logic out_end   = (state_ff == ST_DOUT) && rx_hs && ((wcnt_ff == 12'h1) || RXD_LAST_I);
  wire logic burst_end = in_end || out_end;
  wire logic is_pio    = (cls_ff == CL_PIO_IN) || (cls_ff == CL_PIO_OUT);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (cmd_take) begin
          if (cmd_refuse || (!cmd_nodata && ERR_PEND_I)) begin
            nxt_state = ST_REG; // RL6
          end else if (cmd_nodata) begin
            nxt_state = ST_EXEC; // RL4
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_EXEC: begin
        if (EXEC_DONE_I) begin
          nxt_state = ST_REG; // RL5
        end
      end
      ST_WAIT: begin
        if (XFER_RDY_I) begin
          if (is_pio) begin
            nxt_state = ST_PSET;
          end else if (cls_ff == CL_DMA_IN) begin
            nxt_state = ST_DIN; // RL16
          end else begin
            nxt_state = ST_DACT; // RL18
          end
        end
      end
      ST_PSET: begin
        if (frm_hs) begin
          nxt_state = dir_in_ff ? ST_DIN : ST_DOUT; // RL9
        end
      end
      ST_DACT: begin
        if (frm_hs) begin
          nxt_state = ST_DOUT; // RL19
        end
      end
      ST_DIN: begin
        if (in_end) begin
          if (!burst_last) begin
            nxt_state = ST_WAIT; // RL9
          end else if (cls_ff == CL_PIO_IN) begin
            nxt_state = ST_IDLE; // RL11
          end else begin
            nxt_state = ST_REG; // RL17
          end
        end
      end
      ST_DOUT: begin
        if (out_end) begin
          nxt_state = burst_last ? ST_REG : ST_WAIT; // RL15
        end
      end
      ST_REG: begin
        if (frm_hs) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command context
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cls_ff    <= CL_ABORT;
      dir_in_ff <= 1'b0;
    end else if (cmd_take) begin
      cls_ff    <= cmd_cls;
      dir_in_ff <= cmd_dir_in && !cmd_refuse && !cmd_skip;
    end
  end

  // Error flag for the closing register frame
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      err_ff <= 1'b0;
    end else if (cmd_take) begin
      err_ff <= cmd_refuse || cmd_skip; // RL6
    end else if (state_ff == ST_EXEC && EXEC_DONE_I) begin
      err_ff <= EXEC_ERR_I;
    end else if (out_end && burst_last) begin
      err_ff <= ERR_PEND_I; // RL15
    end
  end

  // Sector and burst accounting
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      remain_ff <= 17'h0;
      burst_ff  <= 5'h0;
      first_ff  <= 1'b0;
    end else if (cmd_take) begin
      remain_ff <= cmd_sect;
      first_ff  <= 1'b1;
    end else if (burst_go) begin
      burst_ff  <= next_burst; // RL10
    end else if (burst_end) begin
      remain_ff <= remain_ff - 17'(burst_ff);
      first_ff  <= 1'b0;
    end
  end

  // Words left in the current data frame
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wcnt_ff <= 12'h0;
    end else if (burst_go) begin
      wcnt_ff <= next_words;
    end else if ((state_ff == ST_DIN && tx_hs) || (state_ff == ST_DOUT && rx_hs)) begin
      wcnt_ff <= wcnt_ff - 12'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device frames

  // Frame request and busy indication
  assign CMD_READY_O = (state_ff == ST_IDLE);
  assign BUSY_O      = (state_ff != ST_IDLE);
  assign FRM_VALID_O = (state_ff == ST_PSET) || (state_ff == ST_DACT) ||
                       ((state_ff == ST_REG) && !fifo_out_valid);

  // Frame header fields
  always_comb begin
    FRM_O             = '0;
    FRM_O.status.drdy = DRDY_I;
    unique case (state_ff)
      ST_PSET: begin
        FRM_O.ftype        = FT_PIO_SETUP; // RL3
        FRM_O.status.drq   = 1'b1; // RL7 RL12
        FRM_O.irq          = dir_in_ff || !first_ff; // RL7 RL12
        FRM_O.e_status.bsy = dir_in_ff ? !burst_last : 1'b1; // RL8 RL13
        FRM_O.xfer_bytes   = 16'(burst_ff * `SDCP_SECT_BYTES);
      end
      ST_DACT: begin
        FRM_O.ftype = FT_DMA_ACT; // RL3
      end
      default: begin
        FRM_O.ftype      = FT_D2H; // RL3
        FRM_O.irq        = 1'b1; // RL5 RL20
        FRM_O.status.err = err_ff;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Data path through the FIFO

  // Media fetch stops at the command's word count, so no stale words linger
  wire logic          mrd_open      = (mrd_left_ff != 24'h0);
  wire logic          fifo_in_valid = dir_in_ff ? (MRD_VALID_I && BUSY_O && mrd_open) :
                                      (RXD_VALID_I && state_ff == ST_DOUT);
  wire logic [DW-1:0] fifo_in_data  = dir_in_ff ? MRD_DATA_I : RXD_DATA_I;
  wire logic          fifo_out_rdy  = dir_in_ff ? (state_ff == ST_DIN && TXD_READY_I) : MWR_READY_I;

  sdcp_fifo #(
    .W (DW),
    .D (`SDCP_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .in_valid_i  (fifo_in_valid),
    .in_data_i   (fifo_in_data),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_out_rdy)
  );

  // Media words still to fetch for a data-in command
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mrd_left_ff <= 24'h0;
    end else if (cmd_take) begin
      mrd_left_ff <= (cmd_dir_in && !cmd_refuse && !cmd_skip) ?
                     24'(cmd_sect) * 24'(`SDCP_SECT_WORDS) : 24'h0;
    end else if (MRD_VALID_I && MRD_READY_O) begin
      mrd_left_ff <= mrd_left_ff - 24'h1;
    end
  end

  // Link and media stream ports
  assign TXD_VALID_O = (state_ff == ST_DIN) && fifo_out_valid; // RL16
  assign TXD_DATA_O  = fifo_out_data;
  assign TXD_LAST_O  = (wcnt_ff == 12'h1); // RL10
  assign RXD_READY_O = !dir_in_ff && (state_ff == ST_DOUT) && fifo_in_ready; // RL14 RL19
  assign MRD_READY_O = dir_in_ff && BUSY_O && mrd_open && fifo_in_ready;
  assign MWR_VALID_O = !dir_in_ff && fifo_out_valid;
  assign MWR_DATA_O  = fifo_out_data;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  a_drdy_gate: assert property (cmd_take && !DRDY_I && !cmd_exempt |=> state_ff == ST_REG && err_ff) // RL2
    else $error("command ran without drive ready");
  a_nodata_exec: assert property (cmd_take && !cmd_refuse && cmd_nodata |=> state_ff == ST_EXEC ##1 !TXD_VALID_O) // RL4
    else $error("non-data command entered a data phase");
  a_nodata_done: assert property (state_ff == ST_EXEC && EXEC_DONE_I |=> FRM_VALID_O && FRM_O.ftype == FT_D2H && FRM_O.irq) // RL5
    else $error("non-data completion frame missing");
  a_pend_skip: assert property (cmd_take && !cmd_refuse && !cmd_nodata && ERR_PEND_I |=> state_ff == ST_REG && err_ff) // RL6
    else $error("pending error did not skip data phase");
  a_pio_in_setup: assert property (FRM_VALID_O && FRM_O.ftype == FT_PIO_SETUP && dir_in_ff |-> // RL7 RL8
    !FRM_O.status.bsy && FRM_O.status.drq && FRM_O.irq && !FRM_O.e_status.drq &&
    FRM_O.e_status.bsy == (remain_ff != 17'(burst_ff)))
    else $error("bad PIO data-in setup status");
  a_pio_out_setup: assert property (FRM_VALID_O && FRM_O.ftype == FT_PIO_SETUP && !dir_in_ff |-> // RL12 RL13
    !FRM_O.status.bsy && FRM_O.status.drq && FRM_O.irq == !first_ff &&
    FRM_O.e_status.bsy && !FRM_O.e_status.drq)
    else $error("bad PIO data-out setup status");
  a_burst_cap: assert property (state_ff inside {ST_DIN, ST_DOUT} |-> // RL10
    wcnt_ff != 12'h0 && wcnt_ff <= 12'(`SDCP_BURST_SECT * `SDCP_SECT_WORDS))
    else $error("burst exceeds 8 KB");
  a_setup_data: assert property (state_ff == ST_PSET && frm_hs |=> state_ff inside {ST_DIN, ST_DOUT}) // RL9
    else $error("setup frame not followed by data");
  a_pio_in_end: assert property (in_end && burst_last && cls_ff == CL_PIO_IN |=> state_ff == ST_IDLE ##1 !FRM_VALID_O) // RL11
    else $error("PIO data-in sent a closing frame");
  a_dma_in_direct: assert property (burst_go && cls_ff == CL_DMA_IN |=> state_ff == ST_DIN && !FRM_VALID_O) // RL16
    else $error("DMA data-in sent a setup frame");
  a_dma_in_close: assert property (in_end && burst_last && cls_ff == CL_DMA_IN |=> state_ff == ST_REG) // RL17
    else $error("DMA data-in not closed by register frame");
  a_dma_act: assert property (burst_go && cls_ff == CL_DMA_OUT |=> FRM_VALID_O && FRM_O.ftype == FT_DMA_ACT) // RL18
    else $error("DMA active frame missing");
  a_out_close: assert property (out_end && burst_last |=> state_ff == ST_REG && FRM_O.irq) // RL15
    else $error("data-out not closed by register frame");
  a_final_irq: assert property (FRM_VALID_O && FRM_O.ftype == FT_D2H |-> FRM_O.irq && !FRM_O.status.bsy) // RL20
    else $error("register frame without interrupt");
  a_frame_hold: assert property (FRM_VALID_O && !FRM_READY_I && state_ff != ST_REG |=> FRM_VALID_O && $stable(FRM_O)) // RL3
    else $error("frame changed while stalled");

  c_nodata: cover property (state_ff == ST_EXEC ##1 state_ff == ST_REG ##[1:20] state_ff == ST_IDLE);
  c_pio_multi: cover property (in_end && !burst_last && cls_ff == CL_PIO_IN);
  c_dma_out: cover property (out_end && burst_last && cls_ff == CL_DMA_OUT);
  c_refuse: cover property (cmd_take && cmd_refuse);
endmodule : sdcp_top

// file: sdcp_host_model.sv
module sdcp_host_model (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              frm_valid_i,
  input  sdcp_pkg::sdcp_frm_t    frm_i,
  input  wire logic [15:0]       burst_i,
  input  wire logic              rxd_ready_i,
  output logic                   frm_ready_o,
  output logic                   txd_ready_o,
  output logic                   rxd_valid_o,
  output logic [31:0]            rxd_data_o,
  output logic                   rxd_last_o
);
  import sdcp_pkg::*;
  logic [15:0] left_ff;
  logic        tgl_ff;
  // Accept frames and read data only every other cycle
  assign frm_ready_o = tgl_ff;
  assign txd_ready_o = tgl_ff;
  // Write burst goes out only after a setup or activate frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {left_ff, tgl_ff, rxd_valid_o, rxd_data_o, rxd_last_o} <= '0;
    end else begin
      tgl_ff <= ~tgl_ff;
      if (rxd_valid_o && !rxd_ready_i) begin
        rxd_valid_o <= 1'b1; // Hold until taken
      end else if (left_ff != 16'h0000) begin
        rxd_valid_o <= 1'b1;
        rxd_data_o  <= rxd_data_o + 32'h00000001;
        rxd_last_o  <= (left_ff == 16'h0001);
        left_ff     <= left_ff - 16'h0001;
      end else begin
        rxd_valid_o <= 1'b0;
        rxd_data_o  <= ~rxd_data_o; // Released line keeps moving
        rxd_last_o  <= 1'b0;
      end
      if (frm_valid_i && frm_ready_o && burst_i != 16'h0000) begin
        if (frm_i.ftype == FT_DMA_ACT) left_ff <= burst_i;
        if (frm_i.ftype == FT_PIO_SETUP) left_ff <= frm_i.xfer_bytes >> 2;
      end
    end
  end
endmodule : sdcp_host_model

// file: sdcp_top_test.sv
`include "sdcp_defines.svh"
module sdcp_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sdcp_pkg::*;
  logic        clk, rst_b, cmd_valid, cmd_ready, drdy, err_pend, exec_done, exec_err, xfer_rdy, busy;
  logic        frm_valid, frm_ready, txd_valid, txd_last, txd_ready, rxd_valid, rxd_last, rxd_ready;
  logic        mrd_valid, mrd_ready, mwr_valid, mwr_ready;
  logic [31:0] txd_data, rxd_data, mrd_data, mwr_data, cyc;
  logic [15:0] burst, n_tx, n_last, n_wr;
  sdcp_cmd_t   cmd;
  sdcp_frm_t   frm;
  sdcp_frm_t   fq[$];
  int          errors, check_count;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  sdcp_top u_sdcp_top (.CORE_CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
    .CMD_READY_O(cmd_ready), .DRDY_I(drdy), .ERR_PEND_I(err_pend), .EXEC_DONE_I(exec_done),
    .EXEC_ERR_I(exec_err), .XFER_RDY_I(xfer_rdy), .BUSY_O(busy), .FRM_VALID_O(frm_valid), .FRM_O(frm),
    .FRM_READY_I(frm_ready), .TXD_VALID_O(txd_valid), .TXD_DATA_O(txd_data), .TXD_LAST_O(txd_last),
    .TXD_READY_I(txd_ready), .RXD_VALID_I(rxd_valid), .RXD_DATA_I(rxd_data), .RXD_LAST_I(rxd_last),
    .RXD_READY_O(rxd_ready), .MRD_VALID_I(mrd_valid), .MRD_DATA_I(mrd_data), .MRD_READY_O(mrd_ready),
    .MWR_VALID_O(mwr_valid), .MWR_DATA_O(mwr_data), .MWR_READY_I(mwr_ready));
  sdcp_host_model u_sdcp_host_model (.clk_i(clk), .rst_b_i(rst_b), .frm_valid_i(frm_valid), .frm_i(frm),
    .burst_i(burst), .rxd_ready_i(rxd_ready), .frm_ready_o(frm_ready), .txd_ready_o(txd_ready),
    .rxd_valid_o(rxd_valid), .rxd_data_o(rxd_data), .rxd_last_o(rxd_last));
  //////////////////////////////////////////////////////////////////////////////
  // Media write side stalls two of four cycles; log frames and words
  always @(posedge clk) begin
    cyc       <= cyc + 32'h00000001;
    mwr_ready <= cyc[1];
    mrd_data  <= cyc;
    if (frm_valid && frm_ready) fq.push_back(frm);
    if (txd_valid && txd_ready) n_tx++;
    if (txd_valid && txd_ready && txd_last) n_last++;
    if (mwr_valid && mwr_ready) n_wr++;
  end
  // Compare one value
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Kind and interrupt bit of a logged frame
  task automatic cf(input int k, input logic [1:0] ft, input logic irq);
    chk("ftype", fq[k].ftype, ft);
    chk("irq", fq[k].irq, irq);
  endtask : cf
  // Verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Issue one command and wait for the return to idle
  task automatic run(input logic [7:0] op, input logic [15:0] cnt, input logic dr, ep, ee, input logic [15:0] bw);
    int i;
    fq.delete();
    {n_tx, n_last, n_wr} = '0;
    chk("busy", 16'(busy), 16'h0000);
    drdy      <= dr;
    err_pend  <= ep;
    exec_err  <= ee;
    burst     <= bw;
    cmd       <= '{op, 8'h00, cnt};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 20000; i++) begin
      @(posedge clk);
      exec_done <= (i == 4);
      #1;
      if (!busy) break;
    end
    exec_done <= 1'b0;
    if (i == 20000) begin
      errors++;
      end_of_test();
    end
  endtask : run
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_nodata;
    run(`SDCP_OP_SEEK, 16'h0001, 1'b1, 1'b0, 1'b1, 16'h0000);
    chk("frames", 16'(fq.size()), 16'h0001);
    cf(0, FT_D2H, 1'b1);
    chk("err", fq[0].status.err, 16'h0001);
    chk("tx", n_tx, 16'h0000);
    $display("non-data done");
  endtask : t_nodata
  task automatic t_drdy;
    run(`SDCP_OP_RECAL, 16'h0001, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk("err", fq[0].status.err, 16'h0001);
    run(`SDCP_OP_DIAG, 16'h0001, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk("err", fq[0].status.err, 16'h0000);
    $display("drive-ready done");
  endtask : t_drdy
  task automatic t_pio_in;
    run(`SDCP_OP_RD_SECT, 16'h0011, 1'b1, 1'b0, 1'b0, 16'h0000);
    chk("frames", 16'(fq.size()), 16'h0002);
    cf(0, FT_PIO_SETUP, 1'b1);
    cf(1, FT_PIO_SETUP, 1'b1);
    chk("st0", {fq[0].status.bsy, fq[0].status.drq}, 16'h0001);
    chk("es0", {fq[0].e_status.bsy, fq[0].e_status.drq}, 16'h0002);
    chk("es1", {fq[1].e_status.bsy, fq[1].e_status.drq}, 16'h0000);
    chk("len0", fq[0].xfer_bytes, 16'h2000);
    chk("len1", fq[1].xfer_bytes, 16'h0200);
    chk("tx", n_tx, 16'h0880);
    chk("lasts", n_last, 16'h0002);
    $display("pio in done");
  endtask : t_pio_in
  task automatic t_pio_out;
    run(`SDCP_OP_WR_SECT, 16'h0011, 1'b1, 1'b0, 1'b0, 16'h0001);
    chk("frames", 16'(fq.size()), 16'h0003);
    cf(0, FT_PIO_SETUP, 1'b0);
    cf(1, FT_PIO_SETUP, 1'b1);
    chk("st0", {fq[0].status.bsy, fq[0].status.drq}, 16'h0001);
    chk("es0", {fq[0].e_status.bsy, fq[0].e_status.drq}, 16'h0002);
    chk("es1", {fq[1].e_status.bsy, fq[1].e_status.drq}, 16'h0002);
    cf(2, FT_D2H, 1'b1);
    chk("err", fq[2].status.err, 16'h0000);
    chk("wr", n_wr, 16'h0880);
    $display("pio out done");
  endtask : t_pio_out
  task automatic t_dma;
    run(`SDCP_OP_RD_DMA, 16'h0002, 1'b1, 1'b0, 1'b0, 16'h0000);
    chk("frames", 16'(fq.size()), 16'h0001);
    cf(0, FT_D2H, 1'b1);
    chk("tx", n_tx, 16'h0100);
    run(`SDCP_OP_WR_DMA, 16'h0001, 1'b1, 1'b0, 1'b0, 16'h0080);
    chk("frames", 16'(fq.size()), 16'h0002);
    cf(0, FT_DMA_ACT, 1'b0);
    cf(1, FT_D2H, 1'b1);
    chk("wr", n_wr, 16'h0080);
    run(`SDCP_OP_RD_DMA, 16'h0001, 1'b1, 1'b1, 1'b0, 16'h0000);
    cf(0, FT_D2H, 1'b1);
    chk("err", fq[0].status.err, 16'h0001);
    chk("tx", n_tx, 16'h0000);
    $display("dma done");
  endtask : t_dma
  //////////////////////////////////////////////////////////////////////////////
  // Reset, then scenarios
  initial begin
    {rst_b, cmd_valid, err_pend, exec_done, exec_err, errors, check_count} = '0;
    {cmd, burst, cyc} = '0;
    {drdy, xfer_rdy, mrd_valid} = 3'h7;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_nodata();
    t_drdy();
    t_pio_in();
    t_pio_out();
    t_dma();
    end_of_test();
  end
endmodule : sdcp_top_test
